// file: logic/sceh_defines.svh
`ifndef SCEH_DEFINES_SVH
`define SCEH_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define SCEH_OFF_SEC_STAT   12'h000
`define SCEH_OFF_SEC_UNC    12'h004
`define SCEH_OFF_UNC_MASK   12'h008
`define SCEH_OFF_UNC_SEV    12'h00c
`define SCEH_OFF_ERR_CTL    12'h010
`define SCEH_OFF_PRI_CSR    12'h014
`define SCEH_OFF_DEV_CSR    12'h018
`define SCEH_OFF_CTRL       12'h01c
`define SCEH_OFF_HDR0       12'h020
`define SCEH_OFF_HDR1       12'h024
`define SCEH_OFF_HDR2       12'h028
`define SCEH_OFF_HDR3       12'h02c

// ==========================================================================
// Secondary status bits
`define SCEH_SS_SIG_TA      0
`define SCEH_SS_RCV_TA      1
`define SCEH_SS_RCV_MA      2
`define SCEH_SS_MDP         3
// Secondary uncorrectable status / mask / severity bits
`define SCEH_UE_RCV_TA      0
`define SCEH_UE_RCV_MA      1
`define SCEH_UE_PERR        2
`define SCEH_UE_USC         3
`define SCEH_UE_SPLIT_MESSAGE_DATA_ERROR        4
`define SCEH_UE_W           5
// Primary control and status bits
`define SCEH_PC_SYSTEM_ERROR_ENABLE     0
`define SCEH_PC_SIG_TA      1
`define SCEH_PC_RCV_TA      2
`define SCEH_PC_SIG_SERR    3
// Device control and status bits
`define SCEH_DC_NF_EN       0
`define SCEH_DC_F_EN        1
`define SCEH_DC_NF_DET      2
`define SCEH_DC_F_DET       3
// Bridge control bits
`define SCEH_CT_PERESP      0
`define SCEH_CT_PCIX        1
// Error pointer control: valid bit, above the 3-bit pointer field
`define SCEH_EP_VALID       3

// ==========================================================================
// Completer error classes and indexes
`define SCEH_CLS_BRIDGE     4'h1
`define SCEH_CLS_COMPL      4'h2
`define SCEH_IDX_MA         8'h00
`define SCEH_IDX_TA         8'h01
`define SCEH_IDX_WDE        8'h02
`define SCEH_IDX_BCNT       8'h00
`define SCEH_IDX_SWDE       8'h01
`define SCEH_IDX_DEVSPEC    4'h8

// Reset values and header log word count
`define SCEH_RST_MASK       5'h00
`define SCEH_RST_SEV        5'h00
`define SCEH_HDR_WORDS      4

`endif

// file: logic/sceh_pkg.sv
package sceh_pkg;

	// Completion status returned upstream
	typedef enum logic [1:0] {
		SCEH_CPL_SC,
		SCEH_CPL_UR,
		SCEH_CPL_CA
	} sceh_cpl_t;

	// Split completion message from the secondary bus
	typedef struct packed {
		logic         valid;
		logic [3:0]   err_class;
		logic [7:0]   err_index;
		logic [127:0] header;
	} sceh_scm_t;

	// Completion answer towards the PCIe requester
	typedef struct packed {
		logic      valid;
		sceh_cpl_t status;
	} sceh_cpl_out_t;

	// Error message towards PCIe
	typedef struct packed {
		logic valid;
		logic fatal;
	} sceh_msg_t;

endpackage

// file: logic/sceh_handler.sv
`timescale 1ns/1ps
`include "sceh_defines.svh"
// Notes on behaviour
// RULE_01: PCIe completer abort on forwarded request sets secondary received-target-abort.
// RULE_02: In PCI mode completer abort becomes delayed Target-Abort after good data.
// RULE_03: Signalling Target-Abort to a PCI agent sets primary received-target-abort.
// RULE_04: PCI-X completer reports failures by a completer-error split message.
// RULE_05: Master-abort message: return UR, set received-master-abort in both registers.
// RULE_06: Target-abort message: return CA, set received/signaled target-abort bits.
// RULE_07: Write data errors: UR, parity-assert seen, data parity if response enabled.
// RULE_08: Byte count out of range: return UR, set no status bits.
// RULE_09: Device-specific error returns CA; any CA sets secondary signaled-target-abort.
// RULE_10: Unexpected split completion sets its status bit and logs the header.
// RULE_11: Parity error on split message data sets the message data error bit.
// RULE_12: Unmasked error with pointer invalid logs header and sets first-error pointer.
// RULE_13: Unmasked error sends fatal/non-fatal message when any reporting enable set; code needs system-error enable or the matching F/NF enable.
// RULE_14: Signaled-system-error sets only when a message was sent and enable set.
// RULE_15: Fatal or non-fatal detected bit sets regardless of mask and enables.

module sceh_handler (
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic [31:0]                 prdata,
	output logic                        pslverr,
	// Completion events from PCIe for forwarded PCI requests
	input  wire logic                   pcie_ca_cpl,
	input  wire logic                   pci_data_done,
	// Secondary bus events
	input  wire sceh_pkg::sceh_scm_t    scm_in,
	input  wire logic                   usc_err,
	input  wire logic                   split_message_data_error_perr,
	// Outputs
	output sceh_pkg::sceh_cpl_out_t     cpl_out,
	output sceh_pkg::sceh_msg_t         err_msg,
	output logic                        pci_target_abort
);

	// ======================================================================
	// State
	logic [3:0]             sec_stat_q;
	logic [`SCEH_UE_W-1:0]  unc_stat_q;
	logic [`SCEH_UE_W-1:0]  unc_mask_q;
	logic [`SCEH_UE_W-1:0]  unc_sev_q;
	logic [3:0]             first_error_pointer_q;
	logic [3:0]             pri_csr_q;
	logic [3:0]             dev_csr_q;
	logic [1:0]             ctrl_q;
	logic [31:0]            hdr_q [`SCEH_HDR_WORDS];
	logic                   ta_pend_q;

	// Per-event decode
	logic [`SCEH_UE_W-1:0]  ev;
	logic                   ev_any;
	logic                   cpl_v;
	sceh_pkg::sceh_cpl_t    cpl_st;
	logic                   dev_spec;
	logic                   first_err;
	logic [2:0]             first_idx;
	logic                   ev_fatal;
	logic                   ev_nonfatal;
	logic                   report_en_f;
	logic                   report_en_nf;
	logic                   msg_go;
	logic                   msg_fatal;
	logic                   wr;
	logic                   rd;

	// Lowest set bit index of an error vector
	function automatic logic [2:0] sceh_first(
		input logic [`SCEH_UE_W-1:0] v
	);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = `SCEH_UE_W - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	// ======================================================================
	// Message decode
	// The partner must send completer-error messages [RULE_04]; only those
	// two classes are decoded, anything else passes without action.
	always_comb begin
		ev       = '0;
		cpl_v    = 1'b0;
		cpl_st   = sceh_pkg::SCEH_CPL_SC;
		dev_spec = 1'b0;
		if (scm_in.valid) begin
			if (scm_in.err_class == `SCEH_CLS_BRIDGE) begin
				case (scm_in.err_index)
					`SCEH_IDX_MA: begin
						cpl_v  = 1'b1;
						cpl_st = sceh_pkg::SCEH_CPL_UR; // [RULE_05]
						ev[`SCEH_UE_RCV_MA] = 1'b1;
					end
					`SCEH_IDX_TA: begin
						cpl_v  = 1'b1;
						cpl_st = sceh_pkg::SCEH_CPL_CA; // [RULE_06]
						ev[`SCEH_UE_RCV_TA] = 1'b1;
					end
					`SCEH_IDX_WDE: begin
						cpl_v  = 1'b1;
						cpl_st = sceh_pkg::SCEH_CPL_UR; // [RULE_07]
						ev[`SCEH_UE_PERR] = 1'b1;
					end
					default: ;
				endcase
			end else if (scm_in.err_class == `SCEH_CLS_COMPL) begin
				if (scm_in.err_index == `SCEH_IDX_BCNT) begin
					cpl_v  = 1'b1;
					cpl_st = sceh_pkg::SCEH_CPL_UR; // [RULE_08]
				end else if (scm_in.err_index == `SCEH_IDX_SWDE) begin
					cpl_v  = 1'b1;
					cpl_st = sceh_pkg::SCEH_CPL_UR; // [RULE_07]
					ev[`SCEH_UE_PERR] = 1'b1;
				end else if (scm_in.err_index[7:4] == `SCEH_IDX_DEVSPEC) begin
					cpl_v    = 1'b1;
					cpl_st   = sceh_pkg::SCEH_CPL_CA; // [RULE_09]
					dev_spec = 1'b1;
				end
			end
		end
		ev[`SCEH_UE_USC]  = usc_err;   // [RULE_10]
		ev[`SCEH_UE_SPLIT_MESSAGE_DATA_ERROR] = split_message_data_error_perr; // [RULE_11]
	end

	// ======================================================================
	// Reporting decisions, shared by every secondary error
	always_comb begin
		ev_any       = |ev;
		ev_fatal     = |(ev & unc_sev_q);
		ev_nonfatal  = |(ev & ~unc_sev_q);
		report_en_f  = pri_csr_q[`SCEH_PC_SYSTEM_ERROR_ENABLE] | dev_csr_q[`SCEH_DC_F_EN];
		report_en_nf = pri_csr_q[`SCEH_PC_SYSTEM_ERROR_ENABLE] | dev_csr_q[`SCEH_DC_NF_EN];
		msg_fatal    = |(ev & ~unc_mask_q & unc_sev_q) & report_en_f;
		msg_go       = msg_fatal |
			(|(ev & ~unc_mask_q & ~unc_sev_q) & report_en_nf); // [RULE_13]
		first_idx    = sceh_first(ev & ~unc_mask_q);
		first_err    = |(ev & ~unc_mask_q) &
			~first_error_pointer_q[`SCEH_EP_VALID];                    // [RULE_12]
		wr = psel & penable & pwrite;
		rd = psel & penable & ~pwrite;
	end

	// ======================================================================
	// APB slave: zero wait states, unmapped addresses read zero and error
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (psel & ~penable) begin
				case (paddr)
					`SCEH_OFF_SEC_STAT: prdata <= {28'h0, sec_stat_q};
					`SCEH_OFF_SEC_UNC:  prdata <= {27'h0, unc_stat_q};
					`SCEH_OFF_UNC_MASK: prdata <= {27'h0, unc_mask_q};
					`SCEH_OFF_UNC_SEV:  prdata <= {27'h0, unc_sev_q};
					`SCEH_OFF_ERR_CTL:  prdata <= {28'h0, first_error_pointer_q};
					`SCEH_OFF_PRI_CSR:  prdata <= {28'h0, pri_csr_q};
					`SCEH_OFF_DEV_CSR:  prdata <= {28'h0, dev_csr_q};
					`SCEH_OFF_CTRL:     prdata <= {30'h0, ctrl_q};
					`SCEH_OFF_HDR0:     prdata <= hdr_q[0];
					`SCEH_OFF_HDR1:     prdata <= hdr_q[1];
					`SCEH_OFF_HDR2:     prdata <= hdr_q[2];
					`SCEH_OFF_HDR3:     prdata <= hdr_q[3];
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// ======================================================================
	// Secondary status; write one clears, hardware set wins over clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_stat_q <= 4'h0;
		end else begin
			sec_stat_q <= (wr && paddr == `SCEH_OFF_SEC_STAT) ?
				sec_stat_q & ~pwdata[3:0] : sec_stat_q;
			if (pcie_ca_cpl) begin
				sec_stat_q[`SCEH_SS_RCV_TA] <= 1'b1; // [RULE_01]
			end
			if (ev[`SCEH_UE_RCV_TA]) begin
				sec_stat_q[`SCEH_SS_RCV_TA] <= 1'b1; // [RULE_06]
			end
			if (ev[`SCEH_UE_RCV_MA]) begin
				sec_stat_q[`SCEH_SS_RCV_MA] <= 1'b1; // [RULE_05]
			end
			if (ev[`SCEH_UE_PERR] & ctrl_q[`SCEH_CT_PERESP]) begin
				sec_stat_q[`SCEH_SS_MDP] <= 1'b1;    // [RULE_07]
			end
			if (cpl_v && cpl_st == sceh_pkg::SCEH_CPL_CA) begin
				sec_stat_q[`SCEH_SS_SIG_TA] <= 1'b1; // [RULE_09]
			end
		end
	end

	// Secondary uncorrectable status; write one clears
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unc_stat_q <= 5'h0;
		end else begin
			unc_stat_q <= ((wr && paddr == `SCEH_OFF_SEC_UNC) ?
				unc_stat_q & ~pwdata[4:0] : unc_stat_q) | ev; // [RULE_05]
		end
	end

	// Mask, severity and bridge control are plain read/write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unc_mask_q <= `SCEH_RST_MASK;
			unc_sev_q  <= `SCEH_RST_SEV;
			ctrl_q     <= 2'h0;
		end else if (wr) begin
			if (paddr == `SCEH_OFF_UNC_MASK) unc_mask_q <= pwdata[4:0];
			if (paddr == `SCEH_OFF_UNC_SEV)  unc_sev_q  <= pwdata[4:0];
			if (paddr == `SCEH_OFF_CTRL)     ctrl_q     <= pwdata[1:0];
		end
	end

	// ======================================================================
	// First-error pointer and header log; software clears the valid bit
	// to re-arm capture, an error in that same cycle is not logged.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_error_pointer_q <= 4'h0;
			for (int i = 0; i < `SCEH_HDR_WORDS; i++) begin
				hdr_q[i] <= 32'h0;
			end
		end else begin
			if (wr && paddr == `SCEH_OFF_ERR_CTL && pwdata[`SCEH_EP_VALID]) begin
				first_error_pointer_q[`SCEH_EP_VALID] <= 1'b0;
			end
			if (first_err) begin
				first_error_pointer_q <= {1'b1, first_idx};             // [RULE_12]
				for (int i = 0; i < `SCEH_HDR_WORDS; i++) begin
					hdr_q[i] <= scm_in.header[32*i +: 32]; // [RULE_10]
				end
			end
		end
	end

	// ======================================================================
	// Primary control/status: enable is R/W, status bits write one clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pri_csr_q <= 4'h0;
		end else begin
			if (wr && paddr == `SCEH_OFF_PRI_CSR) begin
				pri_csr_q <= {pri_csr_q[3:1] & ~pwdata[3:1], pwdata[0]};
			end
			if (ev[`SCEH_UE_RCV_TA]) begin
				pri_csr_q[`SCEH_PC_SIG_TA] <= 1'b1;   // [RULE_06]
			end
			if (ta_pend_q & pci_data_done) begin
				pri_csr_q[`SCEH_PC_RCV_TA] <= 1'b1;   // [RULE_03]
			end
			if (msg_go & pri_csr_q[`SCEH_PC_SYSTEM_ERROR_ENABLE]) begin
				pri_csr_q[`SCEH_PC_SIG_SERR] <= 1'b1; // [RULE_14]
			end
		end
	end

	// Device control/status: detected bits ignore mask and enables
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_csr_q <= 4'h0;
		end else begin
			if (wr && paddr == `SCEH_OFF_DEV_CSR) begin
				dev_csr_q <= {dev_csr_q[3:2] & ~pwdata[3:2], pwdata[1:0]};
			end
			if (ev_fatal) begin
				dev_csr_q[`SCEH_DC_F_DET] <= 1'b1;  // [RULE_15]
			end
			if (ev_nonfatal) begin
				dev_csr_q[`SCEH_DC_NF_DET] <= 1'b1; // [RULE_15]
			end
		end
	end

	// ======================================================================
	// Delayed Target-Abort: good data already returned is delivered first,
	// the abort follows once the PCI side has drained it.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ta_pend_q        <= 1'b0;
			pci_target_abort <= 1'b0;
		end else begin
			pci_target_abort <= ta_pend_q & pci_data_done;     // [RULE_02]
			if (pcie_ca_cpl & ~ctrl_q[`SCEH_CT_PCIX]) begin
				ta_pend_q <= 1'b1;                             // [RULE_02]
			end else if (pci_data_done) begin
				ta_pend_q <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Completion and error message outputs, one-cycle pulses
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpl_out <= '0;
			err_msg <= '0;
		end else begin
			cpl_out.valid  <= cpl_v;
			cpl_out.status <= cpl_st;
			err_msg.valid  <= msg_go;    // [RULE_13]
			err_msg.fatal  <= msg_fatal;
		end
	end

	// Unused unless a future class is decoded
	logic unused_ok;
	assign unused_ok = dev_spec & ev_any;

endmodule

// file: tb/sceh_handler_assertions.sv
`timescale 1ns/1ps
// ============================================
// Completion and message checks
module sceh_handler_assertions (
	input wire logic                    core_clk,
	input wire logic                    rst_n,
	input wire sceh_pkg::sceh_scm_t     scm_in,
	input wire logic                    usc_err,
	input wire logic                    split_message_data_error_perr,
	input wire logic                    pci_data_done,
	input wire sceh_pkg::sceh_cpl_out_t cpl_out,
	input wire sceh_pkg::sceh_msg_t     err_msg,
	input wire logic                    pci_target_abort
);
	localparam sceh_pkg::sceh_cpl_t ur = sceh_pkg::SCEH_CPL_UR;
	localparam sceh_pkg::sceh_cpl_t ca = sceh_pkg::SCEH_CPL_CA;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// One decoded completer error message
	sequence s_code(c, i);
		scm_in.valid && scm_in.err_class == c && scm_in.err_index == i;
	endsequence
	// Answer lands exactly one edge after the message
	property p_ans(c, i, s);
		s_code(c, i) |=> cpl_out.valid && cpl_out.status == s;
	endproperty
	chk_ma_ur: assert property (p_ans(4'h1, 8'h00, ur))
		else $error("master abort answer wrong");
	chk_ta_ca: assert property (p_ans(4'h1, 8'h01, ca))
		else $error("target abort answer wrong");
	chk_wde_ur: assert property (p_ans(4'h1, 8'h02, ur))
		else $error("write data error answer wrong");
	chk_swde_ur: assert property (p_ans(4'h2, 8'h01, ur))
		else $error("split write error answer wrong");
	chk_bcnt_ur: assert property (p_ans(4'h2, 8'h00, ur))
		else $error("byte count answer wrong");
	chk_dev_ca: assert property (scm_in.valid &&
		scm_in.err_class == 4'h2 && scm_in.err_index[7:4] == 4'h8
		|=> cpl_out.valid && cpl_out.status == ca)
		else $error("device specific answer wrong");
	// Abort to the PCI agent only after all good data went out
	chk_abort_order: assert property (
		pci_target_abort |-> $past(pci_data_done))
		else $error("target abort before data done");
	chk_msg_cause: assert property (
		err_msg.valid |-> $past(scm_in.valid || usc_err || split_message_data_error_perr))
		else $error("error message without cause");
endmodule

// file: tb/sceh_split_completer.sv
`timescale 1ns/1ps
// ============================================
// PCI-X target acting as split completer
module sceh_split_completer (
	input wire logic            core_clk,
	output sceh_pkg::sceh_scm_t scm_in,
	output logic                usc_err,
	output logic                split_message_data_error_perr
);
	initial begin
		scm_in = '0;
		usc_err = 1'b0;
		split_message_data_error_perr = 1'b0;
	end
	// Kind 0 message, 1 unexpected completion, 2 data parity error.
	// Gap models a slow completer; idle header is scrambled on purpose
	task automatic send(input logic [1:0] k, input logic [3:0] c,
		input logic [7:0] i, input logic [127:0] h, input int gap);
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		scm_in.valid <= (k == 2'h0);
		scm_in.err_class <= c;
		scm_in.err_index <= i;
		scm_in.header <= h;
		usc_err <= (k == 2'h1);
		split_message_data_error_perr <= (k == 2'h2);
		@(posedge core_clk);
		scm_in.valid <= 1'b0;
		scm_in.header <= ~h;
		usc_err <= 1'b0;
		split_message_data_error_perr <= 1'b0;
	endtask
endmodule

// file: tb/sceh_handler_tb_top.sv
`timescale 1ns/1ps
`include "sceh_defines.svh"
// ============================================
// Bench for the split completion error handler
module sceh_handler_tb_top;
	logic                    core_clk, rst_n, psel, penable, pwrite;
	logic                    pready, pslverr, pcie_ca_cpl, pci_data_done;
	logic                    usc_err, split_message_data_error_perr, pci_target_abort;
	logic                    err_q, cpl_got, msg_got, msg_fat, ta_got;
	logic [11:0]             paddr;
	logic [31:0]             pwdata, prdata, rd_q;
	sceh_pkg::sceh_scm_t     scm_in;
	sceh_pkg::sceh_cpl_out_t cpl_out;
	sceh_pkg::sceh_msg_t     err_msg;
	sceh_pkg::sceh_cpl_t     cpl_st;
	int                      miscompares, num_checks;

	sceh_handler dut (.core_clk, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .pcie_ca_cpl,
		.pci_data_done, .scm_in, .usc_err, .split_message_data_error_perr, .cpl_out,
		.err_msg, .pci_target_abort);
	sceh_split_completer u_cmpl (.core_clk, .scm_in, .usc_err,
		.split_message_data_error_perr);

	// ============================================
	// Clock and one-cycle pulse catchers
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Pulses last one cycle; caught mid-cycle, where they have settled
	always @(negedge core_clk) begin
		if (cpl_out.valid === 1'b1) begin
			cpl_got = 1'b1;
			cpl_st = cpl_out.status;
		end
		if (err_msg.valid === 1'b1) begin
			msg_got = 1'b1;
			msg_fat = err_msg.fatal;
		end
		if (pci_target_abort === 1'b1)
			ta_got = 1'b1;
	end

	// ============================================
	// Shared tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task tally_and_finish();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// APB transfer; waits for pready under a bound
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		// Answer stands unchanged up to the edge that ends the access
		rd_q = prdata;
		err_q = pslverr;
		@(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			miscompares++;
			tally_and_finish();
		end
	endtask
	task rd(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd_q);
	endtask
	task ptr(input string n, input logic e);
		apb(1'b0, `SCEH_OFF_ERR_CTL, 32'h0);
		chk(n, {31'h0, e}, {31'h0, rd_q[3]});
	endtask
	// Answer follows one cycle after, so three falling edges suffice
	task hit(input logic [1:0] k, input logic [3:0] c, input logic [7:0] i,
		input logic [31:0] w, input int gap);
		cpl_got = 1'b0;
		msg_got = 1'b0;
		msg_fat = 1'b0;
		u_cmpl.send(k, c, i, {4{w}}, gap);
		repeat (3) @(negedge core_clk);
	endtask
	task cpl(input string n, input sceh_pkg::sceh_cpl_t s);
		chk(n, {29'h0, 1'b1, s}, {29'h0, cpl_got, cpl_st});
	endtask
	task msg(input string n, input logic [1:0] e);
		chk(n, {30'h0, e}, {30'h0, msg_got, msg_fat});
	endtask
	task clr(input logic serr, input logic [1:0] den, input logic p);
		apb(1'b1, `SCEH_OFF_SEC_STAT, 32'hf);
		apb(1'b1, `SCEH_OFF_SEC_UNC, 32'h1f);
		apb(1'b1, `SCEH_OFF_PRI_CSR, {28'h0, 3'h7, serr});
		apb(1'b1, `SCEH_OFF_DEV_CSR, {28'h0, 2'h3, den});
		if (p)
			apb(1'b1, `SCEH_OFF_ERR_CTL, 32'h8);
	endtask

	// ============================================
	// Scenarios
	task t_reset();
		rd("mask", `SCEH_OFF_UNC_MASK, 32'h0);
		rd("sev", `SCEH_OFF_UNC_SEV, 32'h0);
		ptr("ptr_rst", 1'b0);
		apb(1'b0, 12'h0f0, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err_q});
		$display("test reset done");
	endtask
	// Message codes, first error logged and later one not
	task t_ma_ta();
		apb(1'b1, `SCEH_OFF_CTRL, 32'h2);
		clr(1'b1, 2'h0, 1'b1);
		hit(2'h0, 4'h1, 8'h00, 32'h5a5a0f01, 0);
		cpl("ma_cpl", sceh_pkg::SCEH_CPL_UR);
		msg("ma_msg", 2'h2);
		rd("ma_sec", `SCEH_OFF_SEC_STAT, 32'h4);
		rd("ma_unc", `SCEH_OFF_SEC_UNC, 32'h2);
		rd("ma_hdr", `SCEH_OFF_HDR0, 32'h5a5a0f01);
		ptr("ma_ptr", 1'b1);
		rd("ma_pri", `SCEH_OFF_PRI_CSR, 32'h9);
		rd("ma_dev", `SCEH_OFF_DEV_CSR, 32'h4);
		clr(1'b0, 2'h1, 1'b0);
		hit(2'h0, 4'h1, 8'h01, 32'hc3c30f02, 2);
		cpl("ta_cpl", sceh_pkg::SCEH_CPL_CA);
		msg("ta_msg", 2'h2);
		rd("ta_sec", `SCEH_OFF_SEC_STAT, 32'h3);
		rd("ta_unc", `SCEH_OFF_SEC_UNC, 32'h1);
		rd("ta_pri", `SCEH_OFF_PRI_CSR, 32'h2);
		rd("ta_hdr", `SCEH_OFF_HDR0, 32'h5a5a0f01);
		$display("test master and target abort done");
	endtask
	task t_wde();
		for (int j = 0; j < 4; j++) begin
			apb(1'b1, `SCEH_OFF_CTRL, {30'h0, 1'b1, j[1]});
			clr(1'b0, 2'h0, 1'b1);
			hit(2'h0, j[0] ? 4'h2 : 4'h1, j[0] ? 8'h01 : 8'h02, 32'h0, 0);
			cpl("wde_cpl", sceh_pkg::SCEH_CPL_UR);
			msg("wde_msg", 2'h0);
			rd("wde_unc", `SCEH_OFF_SEC_UNC, 32'h4);
			rd("wde_sec", `SCEH_OFF_SEC_STAT, {28'h0, j[1], 3'h0});
		end
		$display("test write data errors done");
	endtask
	task t_bcnt();
		clr(1'b1, 2'h0, 1'b1);
		hit(2'h0, 4'h2, 8'h00, 32'h1, 0);
		cpl("bc_cpl", sceh_pkg::SCEH_CPL_UR);
		msg("bc_msg", 2'h0);
		rd("bc_sec", `SCEH_OFF_SEC_STAT, 32'h0);
		rd("bc_unc", `SCEH_OFF_SEC_UNC, 32'h0);
		hit(2'h0, 4'h2, 8'h85, 32'h2, 1);
		cpl("ds_cpl", sceh_pkg::SCEH_CPL_CA);
		rd("ds_sec", `SCEH_OFF_SEC_STAT, 32'h1);
		rd("ds_unc", `SCEH_OFF_SEC_UNC, 32'h0);
		$display("test byte count and device error done");
	endtask
	// Masked error still counts as detected; fatal severity honoured
	task t_usc();
		clr(1'b0, 2'h3, 1'b1);
		apb(1'b1, `SCEH_OFF_UNC_MASK, 32'h8);
		apb(1'b1, `SCEH_OFF_UNC_SEV, 32'h10);
		hit(2'h1, 4'h0, 8'h00, 32'h77, 0);
		msg("usc_msg", 2'h0);
		rd("usc_unc", `SCEH_OFF_SEC_UNC, 32'h8);
		ptr("usc_ptr", 1'b0);
		rd("usc_dev", `SCEH_OFF_DEV_CSR, 32'h7);
		hit(2'h2, 4'h0, 8'h00, 32'h99, 1);
		msg("pe_msg", 2'h3);
		rd("pe_unc", `SCEH_OFF_SEC_UNC, 32'h18);
		rd("pe_hdr", `SCEH_OFF_HDR0, 32'h99);
		rd("pe_pri", `SCEH_OFF_PRI_CSR, 32'h0);
		rd("pe_dev", `SCEH_OFF_DEV_CSR, 32'hf);
		apb(1'b1, `SCEH_OFF_UNC_MASK, 32'h0);
		apb(1'b1, `SCEH_OFF_UNC_SEV, 32'h0);
		$display("test split completion faults done");
	endtask
	task t_dta();
		apb(1'b1, `SCEH_OFF_CTRL, 32'h0);
		clr(1'b0, 2'h0, 1'b1);
		ta_got = 1'b0;
		@(posedge core_clk);
		pcie_ca_cpl <= 1'b1;
		@(posedge core_clk);
		pcie_ca_cpl <= 1'b0;
		repeat (3) @(negedge core_clk);
		rd("dta_sec", `SCEH_OFF_SEC_STAT, 32'h2);
		chk("dta_early", 32'h0, {31'h0, ta_got});
		@(posedge core_clk);
		pci_data_done <= 1'b1;
		@(posedge core_clk);
		pci_data_done <= 1'b0;
		repeat (3) @(negedge core_clk);
		chk("dta_abort", 32'h1, {31'h0, ta_got});
		rd("dta_pri", `SCEH_OFF_PRI_CSR, 32'h4);
		$display("test delayed target abort done");
	endtask

	initial begin
		{rst_n, psel, penable, pwrite, pcie_ca_cpl, pci_data_done} = '0;
		{paddr, pwdata} = '0;
		{cpl_got, msg_got, msg_fat, ta_got} = '0;
		miscompares = 0;
		num_checks = 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_ma_ta();
		t_wde();
		t_bcnt();
		t_usc();
		t_dta();
		tally_and_finish();
	end
endmodule

bind sceh_handler sceh_handler_assertions u_chk (.core_clk, .rst_n,
	.scm_in, .usc_err, .split_message_data_error_perr, .pci_data_done, .cpl_out, .err_msg,
	.pci_target_abort);
